// [rtl/charge_timer_test_bypass.sv]
// charge-limit timer with test-mode stage bypass and register slave
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module charge_timer_test_bypass #(
  parameter logic [charge_timer_pkg::HOLD_W-1:0] HOLDOFF_TICKS =
    charge_timer_pkg::HOLD_W'(charge_timer_pkg::HOLDOFF_TICKS),
  parameter logic [charge_timer_pkg::CHAIN_W-1:0] MID_TICKS =
    charge_timer_pkg::CHAIN_W'(charge_timer_pkg::MID_TICKS)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic battery_sense_under_i,
  input wire logic battery_sense_over_i,
  input wire logic limit_select_one_neg_i,
  input wire logic [2:0] limit_select_i,
  input wire logic slope_event_i,
  output logic fast_trickle_o,
  output logic sample_gate_o,
  input wire logic [charge_timer_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [charge_timer_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import charge_timer_pkg::*;

  logic [TICK_W-1:0] pre_reg, pre_next;
  logic [CHAIN_W-1:0] chain_reg, chain_next, step;
  logic [GATE_STAGES-1:0] gate_reg, gate_next, gate_step;
  logic [HOLD_W-1:0] hold_reg, hold_next, hold_step;
  logic [1:0] slopes_reg, slopes_next;
  mode_type mode, mode_reg;
  logic in_win, in_win_reg, latch_reg, latch_next;
  logic fast_next, gate_o_next, tick, restart, expired, hold_done;
  logic gate_carry, sw3, latch_set;
  logic [3:0] limit_n;
  logic force_reg, force_next, restart_sw_reg, restart_sw_next;

  // timer group
  always_comb
  begin
    in_win = !battery_sense_under_i && !battery_sense_over_i;
    sw3 = limit_select_one_neg_i;
    if (battery_sense_under_i && limit_select_one_neg_i)
      mode = MODE_MID;
    else if (battery_sense_under_i)
      mode = MODE_FAST;
    else
      mode = MODE_NORMAL;
    // entering a test mode restarts the chain, so the delay counts
    // from the sense input leaving the window
    restart = (in_win && !in_win_reg) || (mode != mode_reg)
      || restart_sw_reg;
    tick = (pre_reg == TICK_W'(TICK_CYCLES - 1));
    pre_next = tick ? '0 : pre_reg + 1'b1;
    // bypass adds at a later stage; lower stages are left untouched
    unique case (mode)
      MODE_NORMAL: step = CHAIN_W'(1);
      MODE_FAST: step = CHAIN_W'(1) << SW1_SKIP;
      MODE_MID: step = CHAIN_W'(1) << SW2_SKIP;
    endcase
    chain_next = chain_reg;
    if (restart)
      chain_next = '0;
    else if (tick && !chain_reg[CHAIN_STAGES])
      chain_next = chain_reg + step;
    // open select pins give 8/8 of the full limit, each ground less
    limit_n = {1'b0, limit_select_i} + 4'h1;
    if (mode_reg == MODE_MID)
      expired = (chain_reg >= (MID_TICKS << SW2_SKIP));
    else
      expired = (chain_reg[CHAIN_STAGES:LIMIT_TOP] >= limit_n);
    gate_step = sw3 ? GATE_STAGES'(1) << GATE_SKIP
      : GATE_STAGES'(1);
    {gate_carry, gate_next} = {1'b0, gate_reg};
    if (tick)
      {gate_carry, gate_next} = {1'b0, gate_reg} + {1'b0, gate_step};
    gate_o_next = tick ? gate_carry : sample_gate_o;
    hold_done = (hold_reg >= HOLDOFF_TICKS);
    hold_step = sw3 ? HOLD_W'(1) << HOLD_SKIP : HOLD_W'(1);
    hold_next = hold_reg;
    if (restart)
      hold_next = '0;
    else if (tick && !hold_done)
      hold_next = hold_reg + hold_step;
    slopes_next = slopes_reg;
    if (restart)
      slopes_next = 2'h0;
    else if (tick && gate_carry)
    begin
      if (slope_event_i && hold_done)
        slopes_next = (slopes_reg == 2'h2) ? 2'h2 : slopes_reg + 2'h1;
      else
        slopes_next = 2'h0;
    end
    // a set in the same cycle as a restart does not latch: the restart wins
    // expiry is a level that the restart itself clears, so it may not
    // re-set the latch in the restart cycle or the latch never releases
    latch_set = (slopes_next == 2'h2)
      || (expired && mode_reg == MODE_NORMAL && !restart);
    latch_next = latch_set || (latch_reg && !restart);
    // follow the new mode at once: no false fall on test-mode entry
    if (mode != MODE_NORMAL)
      fast_next = !expired || restart;
    else
      fast_next = in_win && !latch_reg && !expired
        && !force_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_reg <= '0;
      chain_reg <= '0;
      gate_reg <= '0;
      hold_reg <= '0;
      slopes_reg <= 2'h0;
      mode_reg <= MODE_NORMAL;
      in_win_reg <= 1'b0;
      latch_reg <= 1'b0;
      fast_trickle_o <= 1'b0;
      sample_gate_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pre_reg <= pre_next;
      chain_reg <= chain_next;
      gate_reg <= gate_next;
      hold_reg <= hold_next;
      slopes_reg <= slopes_next;
      mode_reg <= mode;
      in_win_reg <= in_win;
      latch_reg <= latch_next;
      fast_trickle_o <= fast_next;
      sample_gate_o <= gate_o_next;
    end
  end

  // register slave group
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
  logic [1:0] bresp_next, rresp_next;
  status_type status;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == CTRL_OFF) || (a == STATUS_OFF) || (a == COUNT_OFF);
  endfunction

  always_comb
  begin
    status = '{fast: fast_trickle_o, latched: latch_reg,
      expired: expired, holdoff_done: hold_done,
      mode: mode_reg, slopes: slopes_reg};
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    force_next = force_reg;
    restart_sw_next = 1'b0;
    bvalid_next = s_axi_bvalid_o && !s_axi_bready_i;
    bresp_next = s_axi_bresp_o;
    rvalid_next = s_axi_rvalid_o && !s_axi_rready_i;
    rresp_next = s_axi_rresp_o;
    rdata_next = s_axi_rdata_o;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (aw_full_reg && w_full_reg && !s_axi_bvalid_o)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = reg_hit(awaddr_reg) ? RESP_OKAY : RESP_DECERR;
      if (awaddr_reg == CTRL_OFF && wstrb_reg[0])
      begin
        force_next = wdata_reg[CTRL_FORCE_BIT];
        restart_sw_next = wdata_reg[CTRL_RESTART_BIT];
      end
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_next = 1'b1;
      rresp_next = reg_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_DECERR;
      unique case (s_axi_araddr_i)
        CTRL_OFF: rdata_next = {31'h0, force_reg};
        STATUS_OFF: rdata_next = {24'h0, status};
        COUNT_OFF: rdata_next = chain_reg[31:0];
        default: rdata_next = 32'h0;
      endcase
    end
    // one write and one read in flight; ready drops until answered
    awready_next = !aw_full_next && !bvalid_next;
    wready_next = !w_full_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      force_reg <= CTRL_FORCE_RESET;
      restart_sw_reg <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= RESP_OKAY;
      s_axi_rdata_o <= 32'h0;
    end
    else if (ce_i)
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      force_reg <= force_next;
      restart_sw_reg <= restart_sw_next;
      s_axi_awready_o <= awready_next;
      s_axi_wready_o <= wready_next;
      s_axi_bvalid_o <= bvalid_next;
      s_axi_bresp_o <= bresp_next;
      s_axi_arready_o <= arready_next;
      s_axi_rvalid_o <= rvalid_next;
      s_axi_rresp_o <= rresp_next;
      s_axi_rdata_o <= rdata_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence chain_step_s;
    ce_i && tick && !restart && !chain_reg[CHAIN_STAGES];
  endsequence
  sequence second_slope_s;
    ce_i && tick && gate_carry && hold_done && slope_event_i
      && slopes_reg == 2'h1 && !restart;
  endsequence

  chain_hold_a: assert property (
    chain_reg[CHAIN_STAGES] && !restart |=> chain_reg[CHAIN_STAGES])
    else $error("limit chain left saturation without restart");
  fast_skip_a: assert property (
    chain_step_s and mode == MODE_FAST |=>
    chain_reg[SW1_SKIP-1:0] == $past(chain_reg[SW1_SKIP-1:0])
    && chain_reg != $past(chain_reg))
    else $error("first bypass disturbed low stages or did not count");
  sense_mode_a: assert property (
    battery_sense_under_i |-> mode != MODE_NORMAL)
    else $error("under-window sense did not select a test mode");
  test_fall_a: assert property (
    ce_i && mode_reg != MODE_NORMAL && expired && !restart
    |=> !fast_trickle_o)
    else $error("output stayed high after scaled limit");
  entry_restart_a: assert property (
    ce_i && mode != mode_reg |=> chain_reg == '0)
    else $error("test mode entry did not restart the chain");
  mid_skip_a: assert property (
    chain_step_s and mode == MODE_MID |=>
    chain_reg[SW2_SKIP-1:0] == $past(chain_reg[SW2_SKIP-1:0])
    && chain_reg[SW2_SKIP] != $past(chain_reg[SW2_SKIP]))
    else $error("second bypass did not step stage eleven");
  mid_select_a: assert property (
    battery_sense_under_i && limit_select_one_neg_i |-> mode == MODE_MID)
    else $error("second switch not selected");
  gate_skip_a: assert property (
    ce_i && tick && sw3 |=>
    gate_reg[GATE_SKIP-1:0] == $past(gate_reg[GATE_SKIP-1:0]))
    else $error("gate bypass moved skipped stages");
  hold_skip_a: assert property (
    ce_i && tick && sw3 && !restart && !hold_done |=>
    hold_reg == $past(hold_reg) + (HOLD_W'(1) << HOLD_SKIP))
    else $error("holdoff bypass step wrong");
  window_out_a: assert property (
    ce_i && mode == MODE_NORMAL && !in_win |=> !fast_trickle_o)
    else $error("fast charge outside the sense window");
  slope_latch_a: assert property (
    second_slope_s |=> latch_reg ##1 (latch_reg || $past(restart)))
    else $error("two slope events did not latch trickle");
endmodule // charge_timer_test_bypass
`default_nettype wire

// [inc/charge_timer_pkg.sv]
// constants, register map and types of the charge-limit timer
// Overview of operation
// - limit timer is a 34-stage divider chain, 283 minutes at full length
// - first test switch skips 19 stages, 524,288 times faster
// - first switch on when the sense input is under the charge window and select-one is not biased negative
// - first test mode: output falls after scaled limit, 4.0 to 32.4 ms
// - entering first test mode while charging is harmless
// - second test switch skips 11 stages, 2048 times faster
// - second switch needs sense under window and select-one biased negative
// - second test mode: output falls a nominal 338.8 ms after entry
// - third switch A skips 5 sample-gate stages, 32 times faster
// - third switch B skips 11 holdoff stages, 2048 times faster
// - third switch follows the select-one negative bias alone
// - above the sense window the output drops to trickle
// - two successive slope events after holdoff latch trickle until a restart or reset; in the test modes the output ignores the latch and follows expiry alone
package charge_timer_pkg;
  localparam longint CLK_HZ = 64'd250_000_000;
  localparam int CHAIN_STAGES = 34;
  localparam int CHAIN_W = CHAIN_STAGES + 1;
  localparam longint LIMIT_MIN = 64'd283;
  localparam int TICK_CYCLES =
    int'(LIMIT_MIN * 64'd60 * CLK_HZ / (64'd1 << CHAIN_STAGES));
  localparam int TICK_W = 8;
  localparam int SW1_SKIP = 19;
  localparam int SW2_SKIP = 11;
  localparam int LIMIT_TOP = 31;
  localparam longint MID_DELAY_TENTH_MS = 64'd3388;
  localparam longint MID_TICKS =
    MID_DELAY_TENTH_MS * CLK_HZ / 64'd10000 / longint'(TICK_CYCLES);
  localparam int GATE_STAGES = 10;
  localparam int GATE_SKIP = 5;
  localparam int HOLD_W = 28;
  localparam int HOLD_SKIP = 11;
  localparam longint HOLDOFF_S = 64'd160;
  localparam longint HOLDOFF_TICKS =
    HOLDOFF_S * CLK_HZ / longint'(TICK_CYCLES);
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;
  localparam logic [3:0] COUNT_OFF = 4'h8;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic CTRL_FORCE_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_FAST, MODE_MID} mode_type;
  typedef struct packed {
    logic fast;
    logic latched;
    logic expired;
    logic holdoff_done;
    logic [1:0] mode;
    logic [1:0] slopes;
  } status_type;
endpackage

// [dv/pin_tester_model.sv]
// tester model that drives the sense, select and slope pins
`timescale 1ns/100ps
`default_nettype none
module pin_tester_model (
  input wire logic clk_i,
  output logic under_o,
  output logic over_o,
  output logic neg_o,
  output logic [2:0] sel_o,
  output logic slope_o
);
  initial
  begin
    under_o = 1'b0;
    over_o = 1'b0;
    neg_o = 1'b0;
    sel_o = 3'h7;
    slope_o = 1'b0;
  end
  // pins move just after an edge, like a tester strobe
  task automatic set_pins(input logic u, input logic o, input logic g,
    input logic s);
    @(posedge clk_i);
    under_o <= u;
    over_o <= o;
    neg_o <= g;
    slope_o <= s;
  endtask
  task automatic set_sel(input logic [2:0] s);
    sel_o <= s;
  endtask
endmodule // pin_tester_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the charge-limit timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import charge_timer_pkg::*;
  localparam int TK = 247;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic under, over, neg, slope, fast, gate;
  logic [2:0] sel;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int num_errors = 0, n_checks = 0, cyc = 0, n, t0, t1, t2;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  pin_tester_model pin_tester_model_i (.clk_i(clk), .under_o(under),
    .over_o(over), .neg_o(neg), .sel_o(sel), .slope_o(slope));
  charge_timer_test_bypass #(.HOLDOFF_TICKS(28'h40), .MID_TICKS(35'h8))
    charge_timer_test_bypass_i (.clk_i(clk), .rst_i(rst), .ce_i(ce),
    .battery_sense_under_i(under), .battery_sense_over_i(over),
    .limit_select_one_neg_i(neg), .limit_select_i(sel),
    .slope_event_i(slope), .fast_trickle_o(fast), .sample_gate_o(gate),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        aw = 1'b0;
      if (wready)
        wd = 1'b0;
      awvalid <= aw;
      wvalid <= wd;
    end
    while (!bvalid && n < 50);
    r = bresp;
    check("bvalid", bvalid, 32'h1);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [3:0] a);
    logic ar;
    ar = 1'b1;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        ar = 1'b0;
      arvalid <= ar;
    end
    while (!rvalid && n < 50);
    v = rdata;
    r = rresp;
    check("rvalid", rvalid, 32'h1);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // two count reads one tick apart give exactly one step
  // frozen cycles with ce low must not count towards the tick
  task automatic step_check(input logic [31:0] e, input int hold);
    logic [31:0] c0;
    t0 = cyc;
    axi_read(COUNT_OFF);
    c0 = v;
    if (hold > 0)
    begin
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      ce <= 1'b1;
    end
    while (cyc < t0 + TK + hold)
      @(posedge clk);
    axi_read(COUNT_OFF);
    check("count step", v - c0, e);
  endtask
  task automatic wait_fast(input logic e, input int lim);
    n = 0;
    while (fast !== e && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wait_rise(output int t);
    n = 0;
    while (gate !== 1'b0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    while (gate !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    t = cyc;
  endtask
  initial
  begin
    #(4 * 90000);
    num_errors++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(4));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_read(STATUS_OFF);
    check("status", v[7:0], 32'h80);
    axi_read(CTRL_OFF);
    check("ctrl", v, 32'h0);
    axi_read(4'hc);
    check("rresp", r, RESP_DECERR);
    check("rdata", v, 32'h0);
    axi_write(4'hc, 32'h1);
    check("bresp", r, RESP_DECERR);
    axi_write(CTRL_OFF, 32'h1);
    check("bresp ok", r, RESP_OKAY);
    repeat (2) @(posedge clk);
    check("forced", fast, 32'h0);
    axi_write(CTRL_OFF, 32'h0);
    repeat (2) @(posedge clk);
    check("unforced", fast, 32'h1);
    pin_tester_model_i.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check("over", fast, 32'h0);
    pin_tester_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    check("entry", fast, 32'h1);
    // sw1 expiry needs a million cycles, so only its step is checked
    pin_tester_model_i.set_sel(3'($urandom_range(7, 0)));
    pin_tester_model_i.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    axi_read(STATUS_OFF);
    check("mode sw1", v[3:2], 32'h1);
    check("fast sw1", fast, 32'h1);
    step_check(32'h80000, 0);
    pin_tester_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    t1 = cyc;
    repeat (3) @(posedge clk);
    axi_read(STATUS_OFF);
    check("mode sw2", v[3:2], 32'h2);
    step_check(32'h800, 0);
    wait_fast(1'b0, 3000);
    t2 = cyc - t1;
    check("mid delay", t2 >= 7 * TK && t2 <= 8 * TK + 5, 32'h1);
    axi_read(STATUS_OFF);
    check("expired", v[5], 32'h1);
    pin_tester_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    check("normal", fast, 32'h1);
    step_check(32'h1, TK);
    axi_read(STATUS_OFF);
    check("holdoff slow", v[4], 32'h0);
    pin_tester_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (2 * TK) @(posedge clk);
    axi_read(STATUS_OFF);
    check("mode sw3", v[3:2], 32'h0);
    check("holdoff fast", v[4], 32'h1);
    wait_rise(t1);
    wait_rise(t2);
    check("gate period", t2 - t1, 32 * TK);
    pin_tester_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
    wait_fast(1'b0, 100 * TK);
    axi_read(STATUS_OFF);
    check("latched", v[6], 32'h1);
    pin_tester_model_i.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (40 * TK) @(posedge clk);
    check("held", fast, 32'h0);
    axi_write(CTRL_OFF, 32'h2);
    repeat (2) @(posedge clk);
    check("released", fast, 32'h1);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
